// [tmr_timer8.sv]
// 8-bit timer/counter with one compare unit behind an apb slave
// assumes a single 200 mhz clock; count pin is asynchronous
//
// Functional notes
// - force strobe acts only in normal and clear-on-match modes
// - force strobe applies a match to the output using the selection being written
// - forced match sets no flag and never clears the counter
// - force strobe bit always reads zero
// - mode field bits 6,3: normal, phase pwm, clear-on-match, fast pwm
// - compare buffer loads per mode; fast pwm at max, phase pwm at max counting up
// - nonzero output selection overrides port; direction bit enables driver
// - non-pwm selections: off, toggle, clear, set on match
// - fast pwm: 10 clear on match set at top, 11 inverse
// - phase pwm: 10 clear up-match set down-match, 11 inverse
// - pwm with compare at top and upper bit set: act at top only
// - clock select 0..5: stop, clk, /8, /64, /256, /1024
// - clock select 6 falling, 7 rising edges of count pin
// - count pin edges count even when the pin is an output
// - counter is fully readable and writable by software
// - counter write blocks the match on the next timer clock
// - fast pwm counts to max then zero on next timer clock
// - phase pwm reverses at max, holding max for one timer clock
// - compare flag sets when counter equals compare value
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module tmr_timer8 (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_count_pin,
  output logic             compare_output_pin_o,
  output logic             compare_output_pin_oe,
  output logic             overflow_flag,
  output logic             compare_flag
);
  import tmr_pkg::*;

  typedef struct packed {
    logic [6:0]  ctrl;       // timer_control without the strobe bit
    logic [7:0]  count;
    logic [7:0]  cmp_buf;    // software view of compare_value
    logic [7:0]  cmp_act;    // value the comparator uses
    logic        count_up;
    logic        oc;
    logic        block;
    logic        ovf;
    logic        cmpf;
    logic        ddr;
    logic        port;
    logic [31:0] rdata;
    logic        err;
  } tmr_st_t;

  tmr_st_t st_ff;
  tmr_st_t nxt_st;
  logic    tick;

  // compare output action for a selection: 0 keeps, 1 toggles, else drives value
  function automatic logic oc_apply(input logic [1:0] sel, input logic cur);
    case (sel)
      2'h1:    return ~cur;
      2'h2:    return 1'b0;
      2'h3:    return 1'b1;
      default: return cur;
    endcase
  endfunction

  // mapped-address check, shared by read and write decode
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == OFS_CONTROL) || (a == OFS_COUNT) || (a == OFS_COMPARE) ||
           (a == OFS_FLAGS) || (a == OFS_PINCTL);
  endfunction

  tmr_tick_gen tmr_tick_gen_i (
    .clk              (clk),
    .reset_n          (reset_n),
    .clock_source_sel (st_ff.ctrl[BIT_CS_HI:BIT_CS_LO]),
    .ext_count_pin    (ext_count_pin),
    .tick             (tick)
  );

  logic [1:0] mode;
  logic [1:0] com;
  logic       pwm;
  logic       wr_acc;
  logic       rd_setup;
  logic [7:0] top;
  logic       at_max;
  logic       at_top;
  logic       match;
  logic       ev_ovf;
  logic       ev_cmp;

  // decoded control fields and timer-clock events
  always_comb begin
    mode     = {st_ff.ctrl[BIT_WGM_HI], st_ff.ctrl[BIT_WGM_LO]};
    com      = st_ff.ctrl[BIT_COM_HI:BIT_COM_LO];
    pwm      = st_ff.ctrl[BIT_WGM_LO];
    wr_acc   = psel & penable & pwrite;
    rd_setup = psel & ~penable & ~pwrite;
    top      = (mode == WGM_CLEAR) ? st_ff.cmp_act : CNT_MAX;
    at_max   = st_ff.count == CNT_MAX;
    at_top   = tick & (st_ff.count == top);
    match    = tick & ~st_ff.block & (st_ff.count == st_ff.cmp_act);
    ev_cmp   = match;
    if (mode == WGM_PC_PWM) begin
      ev_ovf = tick & ~st_ff.count_up & (st_ff.count == CNT_BOTTOM);
    end else begin
      ev_ovf = tick & at_max;
    end
  end

  // next state: counter, compare unit, output, flags, apb
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = st_ff.rdata;
    nxt_st.err   = st_ff.err;

    // counting per waveform mode
    if (tick) begin
      nxt_st.block = 1'b0;
      case (mode)
        WGM_NORMAL: begin
          nxt_st.count = st_ff.count + 8'h01;
        end
        WGM_CLEAR: begin
          if (st_ff.count == st_ff.cmp_act) begin
            nxt_st.count = CNT_BOTTOM;
          end else begin
            nxt_st.count = st_ff.count + 8'h01;
          end
        end
        WGM_FAST: begin
          nxt_st.count = at_max ? CNT_BOTTOM : st_ff.count + 8'h01;
        end
        WGM_PC_PWM: begin
          if (st_ff.count_up) begin
            if (at_max) begin
              nxt_st.count_up = 1'b0;
              nxt_st.count    = st_ff.count - 8'h01;
            end else begin
              nxt_st.count = st_ff.count + 8'h01;
            end
          end else if (st_ff.count == CNT_BOTTOM) begin
            nxt_st.count_up = 1'b1;
            nxt_st.count    = st_ff.count + 8'h01;
          end else begin
            nxt_st.count = st_ff.count - 8'h01;
          end
        end
        default: begin
          nxt_st.count = st_ff.count;
        end
      endcase
    end
    if (mode != WGM_PC_PWM) begin
      nxt_st.count_up = 1'b1;
    end

    // compare buffer transfer point
    case (mode)
      WGM_NORMAL, WGM_CLEAR: nxt_st.cmp_act = st_ff.cmp_buf;
      WGM_PC_PWM: begin
        if (tick & st_ff.count_up & at_max) begin
          nxt_st.cmp_act = st_ff.cmp_buf;
        end
      end
      WGM_FAST: begin
        if (tick & at_max) begin
          nxt_st.cmp_act = st_ff.cmp_buf;
        end
      end
      default: nxt_st.cmp_act = st_ff.cmp_act;
    endcase

    // waveform output
    case (mode)
      WGM_NORMAL, WGM_CLEAR: begin
        if (match) begin
          nxt_st.oc = oc_apply(com, st_ff.oc);
        end
      end
      WGM_FAST: begin
        if (com[1]) begin
          if (match && st_ff.cmp_act != CNT_MAX) begin
            nxt_st.oc = com[0];
          end else if (at_top) begin
            nxt_st.oc = ~com[0];
          end
        end
      end
      WGM_PC_PWM: begin
        if (com[1]) begin
          if (st_ff.cmp_act == CNT_MAX) begin
            if (at_top) begin
              nxt_st.oc = ~com[0];                // steady down-match level
            end
          end else if (match) begin
            nxt_st.oc = st_ff.count_up ? com[0] : ~com[0];
          end
        end
      end
      default: nxt_st.oc = st_ff.oc;
    endcase

    // sticky flags: software clear by writing one, a new event wins
    if (wr_acc && paddr == OFS_FLAGS) begin
      if (pwdata[BIT_OVF]) begin
        nxt_st.ovf = 1'b0;
      end
      if (pwdata[BIT_CMP]) begin
        nxt_st.cmpf = 1'b0;
      end
    end
    if (ev_ovf) begin
      nxt_st.ovf = 1'b1;
    end
    if (ev_cmp) begin
      nxt_st.cmpf = 1'b1;
    end

    // register writes take effect in the access phase
    if (wr_acc) begin
      case (paddr)
        OFS_CONTROL: begin
          nxt_st.ctrl = pwdata[6:0];
          // forced match uses the selection being written; no flag, no clear
          if (pwdata[BIT_FORCE] && !pwdata[BIT_WGM_LO]) begin
            nxt_st.oc = oc_apply(pwdata[BIT_COM_HI:BIT_COM_LO], st_ff.oc);
          end
        end
        OFS_COUNT: begin
          nxt_st.count = pwdata[7:0];
          nxt_st.block = 1'b1;
        end
        OFS_COMPARE: begin
          nxt_st.cmp_buf = pwdata[7:0];
        end
        OFS_PINCTL: begin
          nxt_st.ddr  = pwdata[BIT_DIR];
          nxt_st.port = pwdata[BIT_PORT];
        end
        default: begin
          nxt_st.ddr = st_ff.ddr;
        end
      endcase
    end

    // read data and error captured in the setup phase
    if (psel && !penable) begin
      nxt_st.err   = ~addr_ok(paddr);
      nxt_st.rdata = 32'h0000_0000;
      if (rd_setup) begin
        case (paddr)
          OFS_CONTROL: nxt_st.rdata = {25'h0, st_ff.ctrl};
          OFS_COUNT:   nxt_st.rdata = {24'h0, st_ff.count};
          OFS_COMPARE: nxt_st.rdata = {24'h0, st_ff.cmp_buf};
          OFS_FLAGS:   nxt_st.rdata = {30'h0, st_ff.cmpf, st_ff.ovf};
          OFS_PINCTL:  nxt_st.rdata = {30'h0, st_ff.port, st_ff.ddr};
          default:     nxt_st.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff          <= '0;
      st_ff.ctrl     <= RST_CONTROL[6:0];
      st_ff.count    <= RST_COUNT;
      st_ff.cmp_buf  <= RST_COMPARE;
      st_ff.cmp_act  <= RST_COMPARE;
      st_ff.count_up <= 1'b1;
      st_ff.ddr      <= RST_PINCTL[BIT_DIR];
      st_ff.port     <= RST_PINCTL[BIT_PORT];
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs; a zero selection takes the pin from the port latch
  always_comb begin
    pready                = 1'b1;
    prdata                = st_ff.rdata;
    pslverr               = st_ff.err & psel & penable;
    compare_output_pin_o  = (com != 2'h0) ? st_ff.oc : st_ff.port;
    compare_output_pin_oe = st_ff.ddr;
    overflow_flag         = st_ff.ovf;
    compare_flag          = st_ff.cmpf;
  end

endmodule

// [tmr_pkg.sv]
// package for the 8-bit timer/counter with one compare unit
// assumes a 32-bit apb slave, one byte-wide field per aligned word
package tmr_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;  // timer_control
  localparam logic [7:0] OFS_COUNT   = 8'h04;  // timer_count
  localparam logic [7:0] OFS_COMPARE = 8'h08;  // compare_value
  localparam logic [7:0] OFS_FLAGS   = 8'h0c;  // overflow_flag, compare_flag
  localparam logic [7:0] OFS_PINCTL  = 8'h10;  // pin direction and port data

  // timer_control field positions
  localparam int BIT_FORCE   = 7;
  localparam int BIT_WGM_LO  = 6;
  localparam int BIT_COM_HI  = 5;
  localparam int BIT_COM_LO  = 4;
  localparam int BIT_WGM_HI  = 3;
  localparam int BIT_CS_HI   = 2;
  localparam int BIT_CS_LO   = 0;

  // flags and pin control field positions
  localparam int BIT_OVF     = 0;
  localparam int BIT_CMP     = 1;
  localparam int BIT_DIR     = 0;
  localparam int BIT_PORT    = 1;

  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_COUNT   = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'h00;
  localparam logic [1:0] RST_PINCTL  = 2'h0;

  // counter limits
  localparam logic [7:0] CNT_MAX     = 8'hff;
  localparam logic [7:0] CNT_BOTTOM  = 8'h00;

  // prescaler: tap widths for /8, /64, /256, /1024
  localparam int PRE_WIDTH   = 10;
  localparam int TAP_8       = 3;
  localparam int TAP_64      = 6;
  localparam int TAP_256     = 8;
  localparam int TAP_1024    = 10;

  // clock source codes
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // waveform modes, code is {waveform_mode_hi, waveform_mode_lo}
  localparam logic [1:0] WGM_NORMAL  = 2'h0;
  localparam logic [1:0] WGM_PC_PWM  = 2'h1;
  localparam logic [1:0] WGM_CLEAR   = 2'h2;
  localparam logic [1:0] WGM_FAST    = 2'h3;

endpackage

// [tmr_tick_gen.sv]
// timer clock enable: shared prescaler taps or synchronised count pin
// assumes ext_count_pin is asynchronous to clk
`timescale 1ns/1ps
module tmr_tick_gen (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic [2:0]           clock_source_sel,
  input  wire logic                 ext_count_pin,
  output logic                      tick
);
  import tmr_pkg::*;

  typedef struct packed {
    logic [PRE_WIDTH-1:0] presc;
    logic                 s1;
    logic                 s2;
    logic                 s3;
    logic                 lvl;
    logic                 rise;
    logic                 fall;
  } tmr_tick_st_t;

  tmr_tick_st_t st_ff;
  tmr_tick_st_t nxt_st;

  // true on the last clock of each 2**n prescaler period
  function automatic logic tap_hit(input logic [PRE_WIDTH-1:0] p, input int n);
    logic hit;
    hit = 1'b1;
    for (int i = 0; i < PRE_WIDTH; i++) begin
      if (i < n && !p[i]) begin
        hit = 1'b0;
      end
    end
    return hit;
  endfunction

  // free-running prescaler, three-stage pin sampler, edge detector
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.presc = st_ff.presc + 1'b1;
    nxt_st.s1    = ext_count_pin;
    nxt_st.s2    = st_ff.s1;
    nxt_st.s3    = st_ff.s2;
    nxt_st.rise  = 1'b0;
    nxt_st.fall  = 1'b0;
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.lvl  = st_ff.s3;
      nxt_st.rise = st_ff.s3 & ~st_ff.lvl;
      nxt_st.fall = ~st_ff.s3 & st_ff.lvl;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // source select; pin edges count whatever drives the pin
  always_comb begin
    case (clock_source_sel)
      CS_STOP:     tick = 1'b0;
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = tap_hit(st_ff.presc, TAP_8);
      CS_DIV64:    tick = tap_hit(st_ff.presc, TAP_64);
      CS_DIV256:   tick = tap_hit(st_ff.presc, TAP_256);
      CS_DIV1024:  tick = tap_hit(st_ff.presc, TAP_1024);
      CS_EXT_FALL: tick = st_ff.fall;
      CS_EXT_RISE: tick = st_ff.rise;
      default:     tick = 1'b0;
    endcase
  end

endmodule

// [tmr_timer8_props.sv]
// assertions on the apb and pin ports of the timer
// assumes it is bound to tmr_timer8
`timescale 1ns/1ps
module tmr_timer8_props
  import tmr_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_count_pin,
  input wire logic        compare_output_pin_o,
  input wire logic        compare_output_pin_oe,
  input wire logic        overflow_flag,
  input wire logic        compare_flag
);
  logic       acc;
  logic [2:0] cs_ff;
  logic [1:0] stop_cnt_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // access phase qualifier
  assign acc = psel & penable;
  // follow the clock source and count stopped cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_ff       <= CS_STOP;
      stop_cnt_ff <= 2'h0;
    end else begin
      if (acc && pwrite && paddr == OFS_CONTROL)
        cs_ff <= pwdata[2:0];
      if (cs_ff != CS_STOP)
        stop_cnt_ff <= 2'h0;
      else if (stop_cnt_ff != 2'h3)
        stop_cnt_ff <= stop_cnt_ff + 2'h1;
    end
  end
  err_in_access_a: assert property (pslverr |-> acc)
    else $error("error response outside access phase");
  unmapped_zero_a: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  force_reads_zero_a: assert property (
    acc && !pwrite && paddr == OFS_CONTROL |-> !prdata[BIT_FORCE])
    else $error("force strobe read as one");
  count_width_a: assert property (
    acc && !pwrite && paddr == OFS_COUNT |-> prdata[31:8] == 24'h0)
    else $error("count upper bits not zero");
  dir_drives_oe_a: assert property (
    acc && pwrite && paddr == OFS_PINCTL |=> compare_output_pin_oe == $past(pwdata[BIT_DIR]))
    else $error("pin enable does not follow direction bit");
  force_sets_pin_a: assert property (
    acc && pwrite && paddr == OFS_CONTROL && pwdata[7:4] == 4'hb
    |-> ##[1:2] compare_output_pin_o)
    else $error("forced set did not raise pin");
  force_clears_pin_a: assert property (
    acc && pwrite && paddr == OFS_CONTROL && pwdata[7:4] == 4'ha
    |-> ##[1:2] !compare_output_pin_o)
    else $error("forced clear did not lower pin");
  stop_no_flags_a: assert property (
    stop_cnt_ff == 2'h3 |-> !$rose(compare_flag) && !$rose(overflow_flag))
    else $error("flag rose while counter stopped");
endmodule
bind tmr_timer8 tmr_timer8_props tmr_timer8_props_i (.*);

// [tmr_apb_host.sv]
// processor side model: one apb transfer per start pulse
// assumes start is a single-cycle pulse while idle
`timescale 1ns/1ps
module tmr_apb_host (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        start,
  input  wire logic        wr,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  output logic             done,
  output logic [31:0]      rdata,
  output logic             err,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // setup, access held until pready, then release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      psel    <= 1'b0;
      penable <= 1'b0;
      pwrite  <= 1'b0;
      paddr   <= 8'h00;
      pwdata  <= 32'h0;
      done    <= 1'b0;
      rdata   <= 32'h0;
      err     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (psel && penable && pready) begin
        psel    <= 1'b0;
        penable <= 1'b0;
        done    <= 1'b1;
        rdata   <= prdata;
        err     <= pslverr;
      end else if (psel) begin
        penable <= 1'b1;
      end else if (start) begin
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= addr;
        pwdata <= wdata;
      end
    end
  end
endmodule

// [test_timer8_mode_compare_control.sv]
// self-checking bench for the 8-bit timer
// assumes the host model carries every register access
`timescale 1ns/1ps
module test_timer8_mode_compare_control;
  import tmr_pkg::*;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic        ext_count_pin, compare_output_pin_o, compare_output_pin_oe;
  logic        overflow_flag, compare_flag, start, wr, done, err;
  logic [7:0]  paddr, addr;
  logic [31:0] pwdata, prdata, wdata, rdata;
  int          bad_count, total_checks;

  tmr_timer8 tmr_timer8_i (.*);
  tmr_apb_host tmr_apb_host_i (.*);

  // free running clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    start <= 1'b1;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    start <= 1'b0;
    for (i = 0; i < 20 && done !== 1'b1; i++)
      @(negedge clk);
    if (done !== 1'b1) begin
      bad_count++;
      finish_test();
    end
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rdata);
  endtask

  task automatic t_regs();
    rd_chk("control reset", OFS_CONTROL, {24'h0, RST_CONTROL});
    rd_chk("count reset", OFS_COUNT, {24'h0, RST_COUNT});
    rd_chk("unmapped data", 8'h14, 32'h0);
    chk("unmapped err", 1, err);
    bus(1'b1, OFS_CONTROL, 32'hc8);
    rd_chk("mode field", OFS_CONTROL, 32'h48);
    bus(1'b1, OFS_CONTROL, 32'h0);
    bus(1'b1, OFS_COUNT, 32'ha5);
    rd_chk("count rw", OFS_COUNT, 32'ha5);
  endtask

  task automatic t_force();
    logic [7:0] ctl[5] = '{8'hb0, 8'ha0, 8'h90, 8'h90, 8'hf8};
    logic       exp[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    bus(1'b1, OFS_PINCTL, 32'h1);
    chk("pin enable", 1, compare_output_pin_oe);
    foreach (ctl[k]) begin
      bus(1'b1, OFS_CONTROL, {24'h0, ctl[k]});
      repeat (2) @(negedge clk);
      chk("forced pin", exp[k], compare_output_pin_o);
    end
    bus(1'b1, OFS_CONTROL, 32'h98);
    rd_chk("forced no clear", OFS_COUNT, 32'ha5);
    chk("forced no flag", 0, compare_flag);
    bus(1'b1, OFS_CONTROL, 32'h0);
    bus(1'b1, OFS_PINCTL, 32'h3);
    repeat (2) @(negedge clk);
    chk("port data pin", 1, compare_output_pin_o);
  endtask

  task automatic t_prescale();
    int div;
    for (int c = 1; c <= 5; c++) begin
      div = (c == 1) ? 1 : (1 << (3 * c - 3 - (c == 4 ? 1 : 0) - (c == 5 ? 2 : 0)));
      bus(1'b1, OFS_COUNT, 32'h0);
      bus(1'b1, OFS_CONTROL, c);
      repeat (4 * div) @(posedge clk);
      bus(1'b1, OFS_CONTROL, 32'h0);
      bus(1'b0, OFS_COUNT, 32'h0);
      chk("prescaled count", 1, rdata >= 3 && rdata <= 5 + 8 / div);
    end
  endtask

  task automatic t_overflow();
    int i;
    bus(1'b1, OFS_FLAGS, 32'h3);
    bus(1'b1, OFS_COMPARE, 32'h10);
    bus(1'b1, OFS_COUNT, 32'hf0);
    bus(1'b1, OFS_CONTROL, 32'h1);
    for (i = 0; i < 60 && overflow_flag !== 1'b1; i++)
      @(negedge clk);
    chk("overflow", 1, overflow_flag);
    if (overflow_flag !== 1'b1) begin
      finish_test();
    end
    chk("early compare", 0, compare_flag);
    for (i = 0; i < 40 && compare_flag !== 1'b1; i++)
      @(negedge clk);
    chk("compare", 1, compare_flag);
    if (compare_flag !== 1'b1) begin
      finish_test();
    end
    bus(1'b1, OFS_CONTROL, 32'h0);
    bus(1'b0, OFS_COUNT, 32'h0);
    chk("wrapped", 1, rdata < 32'h40);
  endtask

  task automatic t_clear();
    bus(1'b1, OFS_COMPARE, 32'h5);
    bus(1'b1, OFS_COUNT, 32'h0);
    bus(1'b1, OFS_CONTROL, 32'h9);
    repeat (6) begin
      bus(1'b0, OFS_COUNT, 32'h0);
      chk("clear bound", 1, rdata <= 32'h5);
    end
    bus(1'b1, OFS_CONTROL, 32'h0);
  endtask

  task automatic t_pwm(input logic [7:0] ctl, input logic [7:0] cmp, input int n,
                       input int lo, input int hi);
    int highs;
    highs = 0;
    bus(1'b1, OFS_COMPARE, {24'h0, cmp});
    bus(1'b1, OFS_COUNT, 32'h0);
    bus(1'b1, OFS_CONTROL, {24'h0, ctl});
    repeat (n) @(posedge clk);
    repeat (n) begin
      @(negedge clk);
      highs += compare_output_pin_o;
    end
    chk("pwm duty", 1, highs >= lo && highs <= hi);
    bus(1'b1, OFS_CONTROL, 32'h0);
  endtask

  task automatic t_ext();
    for (int c = 6; c <= 7; c++) begin
      bus(1'b1, OFS_COUNT, 32'h0);
      bus(1'b1, OFS_CONTROL, c);
      repeat (3) begin
        repeat (6) @(posedge clk);
        ext_count_pin <= 1'b1;
        repeat (6) @(posedge clk);
        ext_count_pin <= 1'b0;
      end
      repeat (8) @(posedge clk);
      bus(1'b1, OFS_CONTROL, 32'h0);
      rd_chk("pin edges", OFS_COUNT, 32'h3);
    end
  endtask

  // counter write while running suppresses the next match
  task automatic t_block();
    bus(1'b1, OFS_COUNT, 32'h0);
    bus(1'b1, OFS_FLAGS, 32'h3);
    bus(1'b1, OFS_COMPARE, 32'h80);
    bus(1'b1, OFS_CONTROL, 32'h1);
    bus(1'b1, OFS_COUNT, 32'h80);
    repeat (4) @(negedge clk);
    chk("blocked match", 0, compare_flag);
    bus(1'b1, OFS_CONTROL, 32'h0);
  endtask

  // reset, then run every scenario
  initial begin
    reset_n       = 1'b0;
    start         = 1'b0;
    wr            = 1'b0;
    addr          = 8'h00;
    wdata         = 32'h0;
    ext_count_pin = 1'b0;
    bad_count     = 0;
    total_checks  = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_force();
    t_prescale();
    t_overflow();
    t_block();
    t_clear();
    t_pwm(8'h69, 8'h40, 256, 56, 72);
    t_pwm(8'h79, 8'h40, 256, 184, 200);
    t_pwm(8'h69, 8'hff, 256, 256, 256);
    t_pwm(8'h61, 8'h40, 510, 120, 136);
    t_pwm(8'h71, 8'h40, 510, 374, 390);
    t_pwm(8'h61, 8'hff, 510, 510, 510);
    t_ext();
    finish_test();
  end
endmodule
